// File: verilog/dsm_top.sv
/*
 * Data signal modulator: mixes a selected modulator with carrier high or carrier low
 * and drives one modulated output pin; registers reached over classic Wishbone.
 * Assumes all source inputs are synchronous to clk_i and that the bus master is classic single cycle.
 */
// Overview of operation
// - Output carrier-high AND mod, else carrier-low
// - Enable bit activates selected sources
// - Disable forces ground carriers, software modulator
// - Select registers keep contents while disabled
// - Output disabled keeps pin driven low
// - Four-bit field picks sixteen modulator sources
// - Four-bit field picks fifteen carrier-high sources
// - Independent four-bit field picks carrier-low source
// - Sources come from peripherals or pins
// - Synced carriers switch on falling edge
// - Polarity bits invert each selected carrier
// - Reset disables and restores default registers
`timescale 1ns/1ns

module dsm_top
  import dsm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Modulator sources
  input  wire logic [1:0]  capture_compare_i,
  input  wire logic [1:0]  pwm_i,
  input  wire logic [1:0]  spi_sdo_i,
  input  wire logic [1:0]  comparator_i,
  input  wire logic        uart_tx_i,
  input  wire logic        external_modulation_pin_i,
  input  wire logic        oscillator_i,
  input  wire logic [3:0]  logic_cell_i,
  // Carrier-only sources
  input  wire logic        system_clock_i,
  input  wire logic        internal_fast_oscillator_i,
  input  wire logic        reference_clock_output_i,
  input  wire logic        external_carrier_pin_one_i,
  input  wire logic        external_carrier_pin_two_i,
  // Modulated output
  output logic             modulated_output_pin_o
);

  // ==========================================================
  // Register state
  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic [3:0]  src_reg;
  logic [3:0]  src_next;
  logic [7:0]  high_carrier_signal_reg;
  logic [7:0]  high_carrier_signal_next;
  logic [7:0]  low_carrier_signal_reg;
  logic [7:0]  low_carrier_signal_next;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  logic        out_reg;
  logic        out_next;
  logic        mix_next;

  logic        modulator_enable;
  logic        software_modulation_bit;
  logic [3:0]  modulation_source_select;
  logic [3:0]  high_carrier_select;
  logic [3:0]  low_carrier_select;
  logic        high_carrier_signal;
  logic        low_carrier_signal;
  logic        modulator;
  logic        high_active;
  logic        low_active;
  logic        bus_req;
  logic [15:0] carrier_sources;

  // ==========================================================
  // Source selection
  // Sources go in as an argument: a continuous assign does not wake on signals read inside a function
  function automatic logic pick_carrier(input logic [3:0] code, input logic [15:0] srcs);
    pick_carrier = srcs[code];
  endfunction

  // Codes 14 and 15 both select ground
  assign carrier_sources = {1'b0, 1'b0, external_carrier_pin_two_i, external_carrier_pin_one_i,
                            reference_clock_output_i, logic_cell_i, internal_fast_oscillator_i,
                            system_clock_i, oscillator_i, pwm_i, capture_compare_i};

  function automatic logic [31:0] pad_byte(input logic [7:0] b);
    pad_byte = {24'h000000, b};
  endfunction

  assign modulator_enable        = ctrl_reg[`DSM_CTRL_EN_BIT];
  assign software_modulation_bit = ctrl_reg[`DSM_CTRL_SWBIT_BIT];
  // Disabled: carriers to ground, modulator to software bit; stored selects untouched
  assign modulation_source_select = modulator_enable ? src_reg : `DSM_MOD_SW_CODE;
  assign high_carrier_select = modulator_enable ? high_carrier_signal_reg[3:0] : `DSM_CAR_GND_CODE;
  assign low_carrier_select  = modulator_enable ? low_carrier_signal_reg[3:0] : `DSM_CAR_GND_CODE;

  always_comb begin
    case (modulation_source_select)
      4'h0:    modulator = capture_compare_i[0];
      4'h1:    modulator = capture_compare_i[1];
      4'h2:    modulator = pwm_i[0];
      4'h3:    modulator = pwm_i[1];
      4'h4:    modulator = spi_sdo_i[0];
      4'h5:    modulator = spi_sdo_i[1];
      4'h6:    modulator = comparator_i[0];
      4'h7:    modulator = comparator_i[1];
      4'h8:    modulator = uart_tx_i;
      4'h9:    modulator = external_modulation_pin_i;
      4'ha:    modulator = oscillator_i;
      4'hb:    modulator = logic_cell_i[0];
      4'hc:    modulator = logic_cell_i[1];
      4'hd:    modulator = logic_cell_i[2];
      4'he:    modulator = logic_cell_i[3];
      default: modulator = software_modulation_bit;
    endcase
  end

  // Polarity bit is masked only while disabled, so a disabled block stays quiet; enabled, it inverts ground too
  assign high_carrier_signal = pick_carrier(high_carrier_select, carrier_sources) ^
                               (high_carrier_signal_reg[`DSM_CAR_POL_BIT] & modulator_enable);
  assign low_carrier_signal  = pick_carrier(low_carrier_select, carrier_sources) ^
                               (low_carrier_signal_reg[`DSM_CAR_POL_BIT] & modulator_enable);

  // ==========================================================
  // Carrier synchronisation
  dsm_carrier_gate u_high_gate (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .want_i    (modulator),
    .sync_i    (high_carrier_signal_reg[`DSM_CAR_SYNC_BIT]),
    .carrier_i (high_carrier_signal),
    .active_o  (high_active)
  );

  dsm_carrier_gate u_low_gate (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .want_i    (~modulator),
    .sync_i    (low_carrier_signal_reg[`DSM_CAR_SYNC_BIT]),
    .carrier_i (low_carrier_signal),
    .active_o  (low_active)
  );

  // ==========================================================
  // Mixing and output
  always_comb begin
    mix_next = (high_active & high_carrier_signal) | (low_active & low_carrier_signal);
    // Pin idles low while disabled, regardless of output polarity
    out_next = modulator_enable ? (mix_next ^ ctrl_reg[`DSM_CTRL_OPOL_BIT]) : 1'b0;
  end

  // ==========================================================
  // Wishbone slave, one wait state, ack drops after one cycle
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;

  always_comb begin
    ctrl_next = ctrl_reg;
    src_next  = src_reg;
    high_carrier_signal_next = high_carrier_signal_reg;
    low_carrier_signal_next = low_carrier_signal_reg;
    ack_next  = bus_req;
    rdat_next = rdat_reg;
    if (bus_req && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        `DSM_ADDR_CTRL: ctrl_next = wb_dat_i[7:0] & `DSM_CTRL_WMASK;
        `DSM_ADDR_SRC:  src_next  = wb_dat_i[3:0];
        `DSM_ADDR_HIGH_CARRIER_SIGNAL: high_carrier_signal_next = wb_dat_i[7:0] & `DSM_CAR_WMASK;
        `DSM_ADDR_LOW_CARRIER_SIGNAL: low_carrier_signal_next = wb_dat_i[7:0] & `DSM_CAR_WMASK;
        default: ;
      endcase
    end
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        `DSM_ADDR_CTRL: begin
          rdat_next = pad_byte({ctrl_reg[7:4], out_reg, ctrl_reg[2:0]});
        end
        `DSM_ADDR_SRC:  rdat_next = pad_byte({4'h0, src_reg});
        `DSM_ADDR_HIGH_CARRIER_SIGNAL: rdat_next = pad_byte(high_carrier_signal_reg);
        `DSM_ADDR_LOW_CARRIER_SIGNAL: rdat_next = pad_byte(low_carrier_signal_reg);
        default:        rdat_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `DSM_CTRL_RST;
      src_reg  <= `DSM_SRC_RST;
      high_carrier_signal_reg <= {4'h0, `DSM_CARSEL_RST};
      low_carrier_signal_reg <= {4'h0, `DSM_CARSEL_RST};
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h00000000;
      out_reg  <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      src_reg  <= src_next;
      high_carrier_signal_reg <= high_carrier_signal_next;
      low_carrier_signal_reg <= low_carrier_signal_next;
      ack_reg  <= ack_next;
      rdat_reg <= rdat_next;
      out_reg  <= out_next;
    end
  end

  assign wb_ack_o               = ack_reg;
  assign wb_dat_o               = rdat_reg;
  assign modulated_output_pin_o = out_reg;

endmodule // dsm_top

// File: verilog/dsm_defines.svh
/*
 * Register offsets, field positions, reset values and source codes of the data signal modulator.
 * Included by the package, the checker and the testbench; holds definitions only.
 */
`ifndef DSM_DEFINES_SVH
`define DSM_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define DSM_ADDR_CTRL      8'h00
`define DSM_ADDR_SRC       8'h04
`define DSM_ADDR_HIGH_CARRIER_SIGNAL      8'h08
`define DSM_ADDR_LOW_CARRIER_SIGNAL      8'h0c
`define DSM_ADDR_W         8

// ==========================================================
// Control register fields
`define DSM_CTRL_EN_BIT    7
`define DSM_CTRL_OPOL_BIT  4
`define DSM_CTRL_OUT_BIT   3
`define DSM_CTRL_SWBIT_BIT 0
`define DSM_CTRL_WMASK     8'h91

// ==========================================================
// Carrier register fields
`define DSM_CAR_POL_BIT    6
`define DSM_CAR_SYNC_BIT   5
`define DSM_CAR_WMASK      8'h6f
`define DSM_SEL_WMASK      8'h0f

// ==========================================================
// Reset values
`define DSM_CTRL_RST       8'h00
`define DSM_SRC_RST        4'h0
`define DSM_CARSEL_RST     4'h0

// ==========================================================
// Source codes of the software bit (15) and of ground (14)
`define DSM_MOD_SW_CODE    4'hf
`define DSM_CAR_GND_CODE   4'he

`endif

// File: verilog/dsm_pkg.sv
/*
 * Types shared by the data signal modulator modules.
 * Assumes dsm_defines.svh sits on the include path.
 */
`include "dsm_defines.svh"

package dsm_pkg;

  // ==========================================================
  // Carrier tracking state
  typedef enum logic [1:0] {
    DSM_CAR_IDLE,
    DSM_CAR_ACTIVE,
    DSM_CAR_WAIT_FALL,
    DSM_CAR_DRAIN
  } dsm_car_state_t;

endpackage

// File: verilog/dsm_carrier_gate.sv
/*
 * One carrier gate: decides when a carrier is active for mixing, with optional falling-edge sync.
 * Assumes the carrier input is already selected, inverted and synchronous to clk_i.
 */
`timescale 1ns/1ns

module dsm_carrier_gate
  import dsm_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic want_i,
  input  wire logic sync_i,
  input  wire logic carrier_i,
  // Result
  output logic      active_o
);

  dsm_car_state_t state_reg;
  dsm_car_state_t state_next;
  logic           car_prev_reg;
  logic           car_prev_next;
  logic           fall;

  assign fall = car_prev_reg & ~carrier_i;

  // ==========================================================
  // Next state
  always_comb begin
    state_next    = state_reg;
    car_prev_next = carrier_i;
    case (state_reg)
      DSM_CAR_IDLE: begin
        if (want_i && !sync_i) begin
          state_next = DSM_CAR_ACTIVE;
        end else if (want_i) begin
          state_next = DSM_CAR_WAIT_FALL;
        end
      end
      DSM_CAR_WAIT_FALL: begin
        if (!want_i) begin
          state_next = DSM_CAR_IDLE;
        end else if (fall || !sync_i) begin
          state_next = DSM_CAR_ACTIVE;
        end
      end
      DSM_CAR_ACTIVE: begin
        if (!want_i && sync_i) begin
          state_next = fall ? DSM_CAR_IDLE : DSM_CAR_DRAIN;
        end else if (!want_i) begin
          state_next = DSM_CAR_IDLE;
        end
      end
      DSM_CAR_DRAIN: begin
        if (want_i) begin
          state_next = DSM_CAR_ACTIVE;
        end else if (fall || !sync_i) begin
          state_next = DSM_CAR_IDLE;
        end
      end
      default: begin
        state_next = DSM_CAR_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= DSM_CAR_IDLE;
      car_prev_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      car_prev_reg <= car_prev_next;
    end
  end

  // Unsynced carrier switches at once; synced one follows its state
  assign active_o = (want_i && !sync_i) ||
                    (state_reg == DSM_CAR_ACTIVE && (want_i || sync_i)) ||
                    (state_reg == DSM_CAR_DRAIN);

endmodule // dsm_carrier_gate

// File: dv/dsm_checker.sv
/* Port assertions for dsm_top.
   Bound from the testbench; sees only the top ports. */
`timescale 1ns/1ns
`include "dsm_defines.svh"

module dsm_checker (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus and pin
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        modulated_output_pin_o
);
  logic tk;
  logic en_reg;
  logic en_next;

  assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Shadow of the enable bit, taken at the same edge as the design
  always_comb begin
    en_next = en_reg;
    if (tk && wb_we_i && wb_sel_i[0] && wb_adr_i == `DSM_ADDR_CTRL) begin
      en_next = wb_dat_i[`DSM_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    en_reg <= rst_i ? 1'b0 : en_next;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Properties
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_ack_next; tk |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(tk); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_rd_hold; !(tk && !wb_we_i) |=> $stable(wb_dat_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_hi_zero; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
  property p_rst_out; $fell(rst_i) |-> !modulated_output_pin_o && wb_dat_o == 32'h0; endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset state");
  property p_off_low; !en_reg |=> !modulated_output_pin_o; endproperty
  a_off_low: assert property (p_off_low) else $error("pin high off");
  property p_ctrl_rd;
    tk && !wb_we_i && wb_adr_i == `DSM_ADDR_CTRL |=>
      wb_dat_o[3] == $past(modulated_output_pin_o) && wb_dat_o[7] == $past(en_reg);
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl readback");
  c_wr: cover property (tk && wb_we_i);
  c_rd: cover property (tk && !wb_we_i);
  c_pin: cover property ($rose(modulated_output_pin_o));
endmodule // dsm_checker

// File: dv/dsm_source_model.sv
/* Far-side sources: peripheral outputs and pins.
   Levels come from the bench; launched on clk_i like on-chip logic. */
`timescale 1ns/1ns

module dsm_source_model (
  // Clock
  input  wire logic        clk_i,
  // Requested levels and what the sources show
  input  wire logic [19:0] lvl_i,
  output logic      [19:0] src_o
);
  // Registered: real peripheral outputs change only after an edge
  always_ff @(posedge clk_i) begin
    src_o <= lvl_i;
  end
endmodule // dsm_source_model

// File: dv/test_dsm_top.sv
/* Testbench for dsm_top: bus, routing, mixing, enable, sync.
   Assumes design, source model and checker compiled before. */
`timescale 1ns/1ns
`include "dsm_defines.svh"

module test_dsm_top;
  logic        clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        ack;
  logic        pin;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [19:0] lvl;
  logic [19:0] src;
  int          mismatches;
  int          num_checks;

  always #5 clk = ~clk;

  dsm_source_model src_u (.clk_i(clk), .lvl_i(lvl), .src_o(src));

  dsm_top dut_u (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .capture_compare_i(src[1:0]), .pwm_i(src[3:2]), .spi_sdo_i(src[5:4]), .comparator_i(src[7:6]),
    .uart_tx_i(src[8]), .external_modulation_pin_i(src[9]), .oscillator_i(src[10]),
    .logic_cell_i(src[14:11]), .system_clock_i(src[15]), .internal_fast_oscillator_i(src[16]),
    .reference_clock_output_i(src[17]), .external_carrier_pin_one_i(src[18]),
    .external_carrier_pin_two_i(src[19]), .modulated_output_pin_o(pin));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 8'(i * 4), 8'h0);
      chk(q, 32'h0);
    end
  endtask

  task automatic t_en;
    bus(1'b1, `DSM_ADDR_SRC, 8'h0f);
    bus(1'b1, `DSM_ADDR_HIGH_CARRIER_SIGNAL, 8'h4e);
    bus(1'b1, `DSM_ADDR_LOW_CARRIER_SIGNAL, 8'h0e);
    bus(1'b1, `DSM_ADDR_CTRL, 8'h81);
    chk({31'h0, pin}, 32'h1);
    bus(1'b1, `DSM_ADDR_CTRL, 8'h11);
    chk({31'h0, pin}, 32'h0);
    bus(1'b0, `DSM_ADDR_SRC, 8'h0);
    chk(q, 32'h0f);
    bus(1'b0, `DSM_ADDR_HIGH_CARRIER_SIGNAL, 8'h0);
    chk(q, 32'h4e);
    bus(1'b1, `DSM_ADDR_CTRL, 8'hff);
    bus(1'b0, `DSM_ADDR_CTRL, 8'h0);
    chk(q, 32'h91);
    bus(1'b1, `DSM_ADDR_CTRL, 8'h81);
    bus(1'b0, `DSM_ADDR_CTRL, 8'h0);
    chk(q, 32'h89);
  endtask

  task automatic t_mod;
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, `DSM_ADDR_SRC, 8'(i));
      for (int k = 0; k < 2; k++) begin
        lvl <= k ? ~(20'h1 << i) : 20'h1 << i;
        bus(1'b1, `DSM_ADDR_CTRL, 8'h80 | 8'(1 - k));
        settle();
        chk({31'h0, pin}, 32'(1 - k));
      end
    end
  endtask

  task automatic t_car;
    int idx [14] = '{0, 1, 2, 3, 10, 15, 16, 11, 12, 13, 14, 17, 18, 19};
    bus(1'b1, `DSM_ADDR_SRC, 8'h0f);
    for (int h = 0; h < 2; h++) begin
      for (int c = 0; c < 15; c++) begin
        for (int v = 0; v < 4; v++) begin
          lvl <= (c == 14) ? 20'hfffff : (v[1] ? ~(20'h1 << idx[c]) : 20'h1 << idx[c]);
          bus(1'b1, h ? `DSM_ADDR_LOW_CARRIER_SIGNAL : `DSM_ADDR_HIGH_CARRIER_SIGNAL, 8'({v[0], 2'b00, 4'(c)}));
          bus(1'b1, h ? `DSM_ADDR_HIGH_CARRIER_SIGNAL : `DSM_ADDR_LOW_CARRIER_SIGNAL, 8'h0e);
          bus(1'b1, `DSM_ADDR_CTRL, 8'h80 | 8'(1 - h));
          settle();
          chk({31'h0, pin}, 32'((c != 14 && !v[1]) ^ v[0]));
        end
      end
    end
  endtask

  task automatic t_sync;
    bus(1'b1, `DSM_ADDR_LOW_CARRIER_SIGNAL, 8'h0e);
    bus(1'b1, `DSM_ADDR_HIGH_CARRIER_SIGNAL, 8'h20);
    bus(1'b1, `DSM_ADDR_CTRL, 8'h81);
    lvl <= 20'h1;
    settle();
    chk({31'h0, pin}, 32'h0);
    lvl <= 20'h0;
    settle();
    lvl <= 20'h1;
    settle();
    chk({31'h0, pin}, 32'h1);
    bus(1'b1, `DSM_ADDR_CTRL, 8'h80);
    chk({31'h0, pin}, 32'h1);
    // Left carrier falls, so a return must wait for the next fall
    lvl <= 20'h0;
    settle();
    lvl <= 20'h1;
    settle();
    chk({31'h0, pin}, 32'h0);
    bus(1'b1, `DSM_ADDR_CTRL, 8'h81);
    chk({31'h0, pin}, 32'h0);
    lvl <= 20'h0;
    settle();
    lvl <= 20'h1;
    settle();
    chk({31'h0, pin}, 32'h1);
  endtask

  task automatic t_rst2;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({31'h0, pin}, 32'h0);
    t_reset();
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    lvl = 20'h0;
    mismatches = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_en();
    t_mod();
    t_car();
    t_sync();
    t_rst2();
    report_and_stop();
  end

  // Whole run needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule // test_dsm_top

bind dsm_top dsm_checker chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .modulated_output_pin_o(modulated_output_pin_o));
